/* verilog/charger_status_alert_regs.sv */
// Purpose: Charger phase, loop-status and threshold-alert registers
// Assumes: Serial control port delivers decoded register reads and writes
// Notes:   Read data appears one cycle after the read request
module charger_status_alert_regs (
  // Clock, reset and enable
  input  wire logic                           clk_sys,
  input  wire logic                           resetn,
  input  wire logic                           ce,
  // Register port from the serial control port
  input  wire charger_status_pkg::reg_req_t   reg_req,
  output logic                                rd_valid,
  output logic [15:0]                         rd_data,
  // Charger core state
  input  wire charger_status_pkg::charge_phase_t phase_code,
  input  wire charger_status_pkg::reg_loop_t  loop_code,
  // Telemetry comparators and alert enables
  input  wire charger_status_pkg::limit_cond_t limit_cond,
  input  wire logic [15:0]                    alert_enable,
  // Live register contents
  output logic [15:0]                         charge_phase_onehot,
  output logic [15:0]                         control_loop_status,
  output logic [15:0]                         threshold_alert_flags
);

  // Phase decode: a single code gives at most one bit
  logic [15:0] phase_dec;
  always_comb begin
    phase_dec = 16'h0000;
    case (phase_code)
      charger_status_pkg::PH_EQUALIZE:      phase_dec[charger_status_pkg::BIT_EQUALIZE] = 1'b1;
      charger_status_pkg::PH_ABSORB:        phase_dec[charger_status_pkg::BIT_ABSORB] = 1'b1;
      charger_status_pkg::PH_SUSPENDED:     phase_dec[charger_status_pkg::BIT_SUSPENDED] = 1'b1;
      charger_status_pkg::PH_PRECONDITION:  phase_dec[charger_status_pkg::BIT_PRECONDITION] = 1'b1;
      charger_status_pkg::PH_CONST_CUR_VLT: phase_dec[charger_status_pkg::BIT_CONST_CUR_VOLT] = 1'b1;
      charger_status_pkg::PH_THERM_PAUSE:   phase_dec[charger_status_pkg::BIT_THERM_PAUSE] = 1'b1;
      charger_status_pkg::PH_TIMER_TERM:    phase_dec[charger_status_pkg::BIT_TIMER_TERM] = 1'b1;
      charger_status_pkg::PH_LOWCUR_TERM:   phase_dec[charger_status_pkg::BIT_LOWCUR_TERM] = 1'b1;
      charger_status_pkg::PH_TIMEOUT_FAULT: phase_dec[charger_status_pkg::BIT_TIMEOUT_FAULT] = 1'b1;
      charger_status_pkg::PH_BAT_MISSING:   phase_dec[charger_status_pkg::BIT_BAT_MISSING] = 1'b1;
      charger_status_pkg::PH_BAT_SHORTED:   phase_dec[charger_status_pkg::BIT_BAT_SHORTED] = 1'b1;
      default:                              phase_dec = 16'h0000;
    endcase
  end

  wire logic [15:0] next_phase;
  assign next_phase = phase_dec & charger_status_pkg::PHASE_MASK;

  // Charging phases in which a regulation loop is reported
  wire logic charging;
  assign charging = (phase_code == charger_status_pkg::PH_EQUALIZE)
                  | (phase_code == charger_status_pkg::PH_ABSORB)
                  | (phase_code == charger_status_pkg::PH_PRECONDITION)
                  | (phase_code == charger_status_pkg::PH_CONST_CUR_VLT);

  // Loop decode
  logic [15:0] loop_dec;
  always_comb begin
    loop_dec = 16'h0000;
    case (loop_code)
      charger_status_pkg::LOOP_UVCL: loop_dec[charger_status_pkg::BIT_LOOP_UVCL] = 1'b1;
      charger_status_pkg::LOOP_IIN:  loop_dec[charger_status_pkg::BIT_LOOP_IIN] = 1'b1;
      charger_status_pkg::LOOP_ICHG: loop_dec[charger_status_pkg::BIT_LOOP_ICHG] = 1'b1;
      charger_status_pkg::LOOP_VBAT: loop_dec[charger_status_pkg::BIT_LOOP_VBAT] = 1'b1;
      default:                       loop_dec = 16'h0000;
    endcase
  end

  wire logic [15:0] next_loop;
  assign next_loop = charging ? (loop_dec & charger_status_pkg::LOOP_MASK) : 16'h0000;

  // Live state registers, never written by software
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      charge_phase_onehot <= charger_status_pkg::PHASE_RESET;
      control_loop_status <= charger_status_pkg::LOOP_RESET;
    end else if (ce) begin
      charge_phase_onehot <= next_phase;
      control_loop_status <= next_loop;
    end
  end

  // Measurement-valid rising edge
  logic meas_valid_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meas_valid_q <= 1'b0;
    end else if (ce) begin
      meas_valid_q <= limit_cond.meas_valid;
    end
  end

  wire logic meas_valid_rise;
  assign meas_valid_rise = limit_cond.meas_valid & ~meas_valid_q;

  // Alert set requests in bit order
  wire logic [15:0] alert_set;
  assign alert_set[charger_status_pkg::BIT_MEAS_VALID] = meas_valid_rise;
  assign alert_set[14] = 1'b0;
  assign alert_set[13] = limit_cond.qcount_lo;
  assign alert_set[12] = limit_cond.qcount_hi;
  assign alert_set[11] = limit_cond.vbat_lo;
  assign alert_set[10] = limit_cond.vbat_hi;
  assign alert_set[9]  = limit_cond.vin_lo;
  assign alert_set[8]  = limit_cond.vin_hi;
  assign alert_set[7]  = limit_cond.vsys_lo;
  assign alert_set[6]  = limit_cond.vsys_hi;
  assign alert_set[5]  = limit_cond.iin_hi;
  assign alert_set[4]  = limit_cond.ibat_lo;
  assign alert_set[3]  = limit_cond.die_temp_hi;
  assign alert_set[2]  = limit_cond.bsr_hi;
  assign alert_set[1]  = limit_cond.ntc_ratio_hi;
  assign alert_set[0]  = limit_cond.ntc_ratio_lo;

  // Register decode
  wire logic sel_phase;
  wire logic sel_loop;
  wire logic sel_alert;
  wire logic alert_wr;
  assign sel_phase = (reg_req.addr == charger_status_pkg::PHASE_OFFSET);
  assign sel_loop  = (reg_req.addr == charger_status_pkg::LOOP_OFFSET);
  assign sel_alert = (reg_req.addr == charger_status_pkg::ALERT_OFFSET);
  assign alert_wr  = reg_req.wr & sel_alert;

  // Sticky alert flags
  alert_flag_bank #(
    .WIDTH (charger_status_pkg::REG_WIDTH),
    .MASK  (charger_status_pkg::ALERT_MASK)
  ) u_alert_flags (
    .clk_sys      (clk_sys),
    .resetn       (resetn),
    .ce           (ce),
    .enable       (alert_enable),
    .set_req      (alert_set),
    .clear_strobe (alert_wr),
    .clear_data   (reg_req.wdata),
    .flags        (threshold_alert_flags)
  );

  // Read multiplexer, unmapped addresses read zero
  wire logic [15:0] rd_mux;
  assign rd_mux = sel_phase ? (charge_phase_onehot & charger_status_pkg::PHASE_MASK) :
                  sel_loop  ? (control_loop_status & charger_status_pkg::LOOP_MASK) :
                  sel_alert ? (threshold_alert_flags & charger_status_pkg::ALERT_MASK) :
                              16'h0000;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_data  <= charger_status_pkg::RDATA_RESET;
      rd_valid <= 1'b0;
    end else if (ce) begin
      rd_valid <= reg_req.rd;
      if (reg_req.rd) begin
        rd_data <= rd_mux;
      end
    end
  end

endmodule

/* verilog/charger_status_pkg.sv */
// Purpose: Shared constants and types for the charger status and alert registers
// Assumes: 8-bit sub-addresses and 16-bit register words on the serial control port
// Notes:   Bit positions follow the register layouts exactly
package charger_status_pkg;

  // Register sub-addresses
  localparam logic [7:0]  PHASE_OFFSET       = 8'h34;
  localparam logic [7:0]  LOOP_OFFSET        = 8'h35;
  localparam logic [7:0]  ALERT_OFFSET       = 8'h36;

  // Register width and implemented-bit masks
  localparam int          REG_WIDTH          = 16;
  localparam logic [15:0] PHASE_MASK         = 16'h07ff;
  localparam logic [15:0] LOOP_MASK          = 16'h000f;
  localparam logic [15:0] ALERT_MASK         = 16'hbfff;

  // Reset values
  localparam logic [15:0] PHASE_RESET        = 16'h0000;
  localparam logic [15:0] LOOP_RESET         = 16'h0000;
  localparam logic [15:0] ALERT_RESET        = 16'h0000;
  localparam logic [15:0] RDATA_RESET        = 16'h0000;

  // Phase register bit positions
  localparam int          BIT_EQUALIZE       = 10;
  localparam int          BIT_ABSORB         = 9;
  localparam int          BIT_SUSPENDED      = 8;
  localparam int          BIT_PRECONDITION   = 7;
  localparam int          BIT_CONST_CUR_VOLT = 6;
  localparam int          BIT_THERM_PAUSE    = 5;
  localparam int          BIT_TIMER_TERM     = 4;
  localparam int          BIT_LOWCUR_TERM    = 3;
  localparam int          BIT_TIMEOUT_FAULT  = 2;
  localparam int          BIT_BAT_MISSING    = 1;
  localparam int          BIT_BAT_SHORTED    = 0;

  // Loop-status bit positions
  localparam int          BIT_LOOP_UVCL      = 3;
  localparam int          BIT_LOOP_IIN       = 2;
  localparam int          BIT_LOOP_ICHG      = 1;
  localparam int          BIT_LOOP_VBAT      = 0;

  // Alert bit used for the measurement-valid edge
  localparam int          BIT_MEAS_VALID     = 15;

  // Phase code from the charger core
  typedef enum logic [3:0] {
    PH_IDLE          = 4'b0000,
    PH_EQUALIZE      = 4'b0001,
    PH_ABSORB        = 4'b0010,
    PH_SUSPENDED     = 4'b0011,
    PH_PRECONDITION  = 4'b0100,
    PH_CONST_CUR_VLT = 4'b0101,
    PH_THERM_PAUSE   = 4'b0110,
    PH_TIMER_TERM    = 4'b0111,
    PH_LOWCUR_TERM   = 4'b1000,
    PH_TIMEOUT_FAULT = 4'b1001,
    PH_BAT_MISSING   = 4'b1010,
    PH_BAT_SHORTED   = 4'b1011
  } charge_phase_t;

  // Regulation loop in control, from the charger core
  typedef enum logic [2:0] {
    LOOP_NONE = 3'b000,
    LOOP_UVCL = 3'b001,
    LOOP_IIN  = 3'b010,
    LOOP_ICHG = 3'b011,
    LOOP_VBAT = 3'b100
  } reg_loop_t;

  // Register access request from the serial control port
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  // Limit comparator outputs, packed in alert-bit order 15 down to 0
  typedef struct packed {
    logic meas_valid;
    logic unused14;
    logic qcount_lo;
    logic qcount_hi;
    logic vbat_lo;
    logic vbat_hi;
    logic vin_lo;
    logic vin_hi;
    logic vsys_lo;
    logic vsys_hi;
    logic iin_hi;
    logic ibat_lo;
    logic die_temp_hi;
    logic bsr_hi;
    logic ntc_ratio_hi;
    logic ntc_ratio_lo;
  } limit_cond_t;

endpackage

/* verilog/alert_flag_bank.sv */
// Purpose: Bank of sticky alert flags with per-bit enable and write-zero clear
// Assumes: Conditions are single-cycle or level requests, synchronous to clk_sys
// Notes:   A set in the same cycle as a clear wins
module alert_flag_bank #(
  parameter int          WIDTH = 16,
  parameter logic [15:0] MASK  = 16'hbfff
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  input  wire logic             ce,
  // Control
  input  wire logic [WIDTH-1:0] enable,
  input  wire logic [WIDTH-1:0] set_req,
  input  wire logic             clear_strobe,
  input  wire logic [WIDTH-1:0] clear_data,
  // Flags
  output logic      [WIDTH-1:0] flags
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      wire logic set_bit;
      wire logic clr_bit;
      wire logic next_flag;
      assign set_bit   = MASK[i] & enable[i] & set_req[i];
      assign clr_bit   = clear_strobe & ~clear_data[i];
      assign next_flag = MASK[i] & enable[i] & (set_bit | (flags[i] & ~clr_bit));
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          flags[i] <= 1'b0;
        end else if (ce) begin
          flags[i] <= next_flag;
        end
      end
    end
  endgenerate

endmodule

/* dv/charger_status_alert_properties.sv */
// Purpose: Port-level properties for the charger status and alert registers
// Assumes: One clock domain, resetn asynchronous and active low
// Notes:   Bound to every instance of the top module
module charger_status_alert_props (
  // Clock, reset and enable
  input wire logic                              clk_sys,
  input wire logic                              resetn,
  input wire logic                              ce,
  // Register port
  input wire charger_status_pkg::reg_req_t      reg_req,
  input wire logic                              rd_valid,
  input wire logic [15:0]                       rd_data,
  // Status inputs
  input wire charger_status_pkg::charge_phase_t phase_code,
  input wire charger_status_pkg::reg_loop_t     loop_code,
  input wire charger_status_pkg::limit_cond_t   limit_cond,
  input wire logic [15:0]                       alert_enable,
  // Register contents
  input wire logic [15:0]                       charge_phase_onehot,
  input wire logic [15:0]                       control_loop_status,
  input wire logic [15:0]                       threshold_alert_flags
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire logic [3:0]  pc        = phase_code;
  wire logic [2:0]  lc        = loop_code;
  wire logic        charging  = pc inside {4'h1, 4'h2, 4'h4, 4'h5};
  wire logic [15:0] exp_phase = (pc >= 4'h1 && pc <= 4'hb) ? 16'h0001 << (4'hb - pc) : 16'h0000;
  wire logic [15:0] exp_loop  = (charging && lc >= 3'h1 && lc <= 3'h4) ?
                                16'h0001 << (3'h4 - lc) : 16'h0000;
  wire logic [15:0] set_lvl   = alert_enable & limit_cond & 16'h3fff;
  wire logic [15:0] kept      = threshold_alert_flags & alert_enable;
  wire logic        wr_alert  = ce && reg_req.wr && reg_req.addr == charger_status_pkg::ALERT_OFFSET;
  sequence s_rd_taken;
    ce && reg_req.rd;
  endsequence
  sequence s_rd_alert;
    s_rd_taken ##0 reg_req.addr == charger_status_pkg::ALERT_OFFSET;
  endsequence
  a_reserved_zero: assert property (charge_phase_onehot[15:11] == 5'h00 &&
    control_loop_status[15:4] == 12'h000 && !threshold_alert_flags[14])
    else $error("reserved bit set");
  a_phase_decode: assert property (ce |=> charge_phase_onehot == $past(exp_phase))
    else $error("phase register wrong");
  a_loop_decode: assert property (ce |=> control_loop_status == $past(exp_loop))
    else $error("loop status wrong");
  a_alert_gated: assert property (ce |=> (threshold_alert_flags & ~$past(alert_enable)) == 16'h0000)
    else $error("disabled alert set");
  a_alert_sets: assert property (ce |=> (threshold_alert_flags & $past(set_lvl)) == $past(set_lvl))
    else $error("alert not set");
  a_alert_sticky: assert property (ce && !wr_alert |=> (threshold_alert_flags & $past(kept)) == $past(kept))
    else $error("alert lost");
  a_write_clear: assert property (wr_alert |=>
    (threshold_alert_flags & ~$past(reg_req.wdata | limit_cond)) == 16'h0000)
    else $error("alert not cleared");
  a_meas_edge: assert property (ce && $past(ce) && $rose(limit_cond.meas_valid) &&
    alert_enable[15] |=>
    threshold_alert_flags[15]) else $error("valid alert missing");
  a_read_alert: assert property (s_rd_alert |=> rd_valid && rd_data == $past(threshold_alert_flags))
    else $error("alert read wrong");
  a_rd_pulse: assert property (ce && !reg_req.rd |=> !rd_valid)
    else $error("stray read valid");
  a_hold_frozen: assert property (!ce |=> $stable(charge_phase_onehot) &&
    $stable(control_loop_status) && $stable(threshold_alert_flags) && $stable(rd_valid))
    else $error("state moved while frozen");
endmodule

bind charger_status_alert_regs charger_status_alert_props i_props (
  .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .reg_req(reg_req), .rd_valid(rd_valid),
  .rd_data(rd_data), .phase_code(phase_code), .loop_code(loop_code), .limit_cond(limit_cond),
  .alert_enable(alert_enable), .charge_phase_onehot(charge_phase_onehot),
  .control_loop_status(control_loop_status), .threshold_alert_flags(threshold_alert_flags)
);

/* dv/test_charger_status_alert_regs.sv */
// Purpose: Self-checking bench for the charger status and alert registers
// Assumes: Inputs change 2 ns after each rising edge
// Notes:   Read data is judged one cycle after the request
module test_charger_status_alert_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic                              clk_sys, resetn, ce, rd_valid;
  logic [15:0]                       rd_data, alert_enable, phase_oh, loop_st, flags;
  charger_status_pkg::reg_req_t      req;
  charger_status_pkg::charge_phase_t phase_code;
  charger_status_pkg::reg_loop_t     loop_code;
  charger_status_pkg::limit_cond_t   limit_cond;
  int                                errors, n_tests, cycles;

  charger_status_alert_regs i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .ce(ce), .reg_req(req), .rd_valid(rd_valid),
    .rd_data(rd_data), .phase_code(phase_code), .loop_code(loop_code), .limit_cond(limit_cond),
    .alert_enable(alert_enable), .charge_phase_onehot(phase_oh), .control_loop_status(loop_st),
    .threshold_alert_flags(flags));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task step;
    @(posedge clk_sys);
    #2;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    step;
    req.wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    req.rd = 1'b1;
    req.addr = a;
    step;
    req.rd = 1'b0;
    chk("rd_valid", 16'h0001, {15'h0000, rd_valid});
    chk("rd_data", e, rd_data);
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task t_reset;
    rd(charger_status_pkg::PHASE_OFFSET, 16'h0000);
    rd(charger_status_pkg::LOOP_OFFSET, 16'h0000);
    rd(charger_status_pkg::ALERT_OFFSET, 16'h0000);
    $display("t_reset done");
  endtask
  task t_phase;
    logic [15:0] e;
    for (int c = 0; c < 12; c++) begin
      phase_code = charger_status_pkg::charge_phase_t'(c);
      step;
      e = (c == 0) ? 16'h0000 : 16'h0001 << (11 - c);
      chk("phase", e, phase_oh);
      rd(charger_status_pkg::PHASE_OFFSET, e);
    end
    wr(charger_status_pkg::PHASE_OFFSET, 16'hffff);
    rd(charger_status_pkg::PHASE_OFFSET, 16'h0001);
    $display("t_phase done");
  endtask
  task t_loop;
    logic [15:0] e;
    for (int p = 0; p < 6; p++) begin
      for (int l = 0; l < 5; l++) begin
        phase_code = charger_status_pkg::charge_phase_t'(p);
        loop_code = charger_status_pkg::reg_loop_t'(l);
        step;
        e = (p inside {1, 2, 4, 5} && l != 0) ? 16'h0001 << (4 - l) : 16'h0000;
        chk("loop", e, loop_st);
      end
    end
    wr(charger_status_pkg::LOOP_OFFSET, 16'hfff0);
    rd(charger_status_pkg::LOOP_OFFSET, 16'h0001);
    $display("t_loop done");
  endtask
  task t_alert;
    logic [15:0] e;
    e = 16'h0000;
    alert_enable = 16'h7ffb;
    for (int b = 0; b < 15; b++) begin
      limit_cond = 16'h0001 << b;
      step;
      limit_cond = 16'h0000;
      step;
      e = e | ((16'h0001 << b) & 16'h3ffb);
      chk("flags", e, flags);
    end
    wr(charger_status_pkg::ALERT_OFFSET, 16'hfaf5);
    rd(charger_status_pkg::ALERT_OFFSET, e & 16'hfaf5);
    wr(charger_status_pkg::ALERT_OFFSET, 16'hffff);
    rd(8'h40, 16'h0000);
    chk("flags", e & 16'hfaf5, flags);
    alert_enable = 16'h0000;
    step;
    chk("flags", 16'h0000, flags);
    alert_enable = 16'h7ffb;
    step;
    chk("flags", 16'h0000, flags);
    $display("t_alert done");
  endtask
  task t_meas;
    alert_enable = 16'h8400;
    limit_cond = 16'h8400;
    step;
    step;
    chk("flags", 16'h8400, flags);
    wr(charger_status_pkg::ALERT_OFFSET, 16'h0000);
    chk("flags", 16'h0400, flags);
    limit_cond = 16'h0000;
    step;
    limit_cond = 16'h8000;
    step;
    chk("flags", 16'h8400, flags);
    $display("t_meas done");
  endtask
  task t_freeze;
    ce = 1'b0;
    phase_code = charger_status_pkg::PH_BAT_MISSING;
    alert_enable = 16'h0000;
    req.rd = 1'b1;
    req.addr = charger_status_pkg::PHASE_OFFSET;
    step;
    req.rd = 1'b0;
    chk("phase", 16'h0040, phase_oh);
    chk("flags", 16'h8400, flags);
    chk("rd_valid", 16'h0000, {15'h0000, rd_valid});
    ce = 1'b1;
    step;
    chk("phase", 16'h0002, phase_oh);
    chk("flags", 16'h0000, flags);
    chk("rd_valid", 16'h0000, {15'h0000, rd_valid});
    $display("t_freeze done");
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      end_sim;
    end
  end

  initial begin
    {errors, n_tests, cycles} = '0;
    resetn = 1'b0;
    ce = 1'b1;
    req = '0;
    phase_code = charger_status_pkg::PH_IDLE;
    loop_code = charger_status_pkg::LOOP_NONE;
    limit_cond = '0;
    alert_enable = 16'h0000;
    repeat (20) @(posedge clk_sys);
    #2;
    resetn = 1'b1;
    t_reset;
    t_phase;
    t_loop;
    t_alert;
    t_meas;
    t_freeze;
    end_sim;
  end
endmodule
